// *** shared/ssx_defines.vh ***
// Constants for the string subtract / xor / vectored call execution block
`ifndef SSX_DEFINES_VH
`define SSX_DEFINES_VH
// Operation codes presented on op_i
`define SSX_OP_NONE      4'h0
`define SSX_OP_STRING_SUBTRACT      4'h1
`define SSX_OP_STRING_SUBTRACT_PH   4'h2
`define SSX_OP_SXM       4'h3
`define SSX_OP_VECTORED_CALL     4'h4
`define SSX_OP_XOR       4'h5
`define SSX_OP_XOR_TFM   4'h6
`define SSX_OP_XOR_TFC   4'h7
`define SSX_OP_SHR       4'h8
// Status word bit positions
`define SSX_ST_XM        0
`define SSX_ST_TF1       1
`define SSX_ST_TF2       2
`define SSX_ST_OF        3
`define SSX_ST_SF        4
`define SSX_ST_ZF        5
`define SSX_ST_CF        6
`define SSX_ST_TAG       7
`define SSX_STAT_RST     8'h00
// Vector table base
`define SSX_VEC_BASE     16'h7f00
// Condition codes
`define SSX_CC_CARRY     3'h0
`define SSX_CC_ZERO      3'h1
`define SSX_CC_TAG       3'h2
`define SSX_CC_RZ        3'h4
`define SSX_CC_RNZ       3'h5
`define SSX_CC_RNEG      3'h6
`define SSX_CC_RNNEG     3'h7
// Pointer modify codes
`define SSX_MOD_NONE     2'h0
`define SSX_MOD_INC      2'h1
`define SSX_MOD_DEC      2'h2
`endif

// *** rtl/ssx_exec.v ***
// Execution unit for string subtract, xor, sign mode and vectored call
//
// Operation
// - String subtract writes dest minus src, or dest minus the memory word, into the destination string.
// - Subtraction is two's complement, so carry can set on a smaller-from-larger subtract.
// - The product-high form runs once, ignoring the count, chaining the prior carry and zero.
// - The product-high form subtracts from the second word and writes only that word.
// - Set-sign-extension sets status bit 0, one cycle, other flags kept, counter plus one.
// - Vectored call pushes the next address and loads the counter from table base plus vector.
// - Xor writes the bitwise xor into the destination after any pointer pre-modify.
// - Xor-to-flag xors the selected test flag with the addressed word's tag bit.
// - Register-zero is true when the index register is zero and is xored into the test flag.
// - Memory operands update the tag flag; accumulator results update overflow, sign, zero, carry.
// - With sign-extension mode set, right shifts fill the top bit from the sign.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "ssx_defines.vh"
module ssx_exec #(
    parameter W    = 16,
    parameter NACC = 8,
    parameter AW   = 3
) (
    // Clock and reset
    input  wire            sys_clk_i,
    input  wire            rstn_i,
    // Instruction issue
    input  wire            start_i,
    input  wire [3:0]      op_i,
    input  wire [AW-1:0]   dst_i,
    input  wire [AW-1:0]   src_i,
    input  wire            use_mem_i,
    input  wire [1:0]      mod_i,
    input  wire [AW-1:0]   count_i,
    input  wire [15:0]     pc_i,
    input  wire [7:0]      vector_i,
    input  wire            tf_sel_i,
    input  wire            flag_not_i,
    input  wire [2:0]      cc_i,
    input  wire [W-1:0]    index_reg_i,
    // Operand memory word
    input  wire [W-1:0]    mem_data_i,
    input  wire            mem_tag_i,
    input  wire [W-1:0]    product_high_reg_i,
    // Accumulator load port
    input  wire            acc_we_i,
    input  wire [AW-1:0]   acc_addr_i,
    input  wire [W-1:0]    acc_data_i,
    // Results
    output reg             busy_o,
    output reg             done_o,
    output reg  [15:0]     pc_o,
    output reg             push_o,
    output reg  [15:0]     push_data_o,
    output reg  [15:0]     vec_addr_o,
    output reg  [7:0]      status_o,
    output reg  [AW-1:0]   acc_pointer_o,
    output reg  [W-1:0]    acc_rd_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_VEC  = 2'h2;

    ////////////////////////////////////////////////////////////////////
    reg [W-1:0]   acc_q [0:NACC-1];
    reg [1:0]     state_q;
    reg [3:0]     op_q;
    reg [AW-1:0]  dst_q;
    reg [AW-1:0]  src_q;
    reg [AW-1:0]  cnt_q;
    reg [AW-1:0]  idx_q;
    reg           mem_q;
    reg           borrow_q;
    reg           zacc_q;
    reg [15:0]    pc_q;
    integer       i;

    function [AW-1:0] ptr_mod;
        input [AW-1:0] p;
        input [1:0]    m;
        begin
            case (m)
                `SSX_MOD_INC: ptr_mod = p + {{(AW-1){1'b0}}, 1'b1};
                `SSX_MOD_DEC: ptr_mod = p - {{(AW-1){1'b0}}, 1'b1};
                default:      ptr_mod = p;
            endcase
        end
    endfunction

    // Subtract with borrow in, returns {carry, result}
    function [W:0] sub_w;
        input [W-1:0] a;
        input [W-1:0] b;
        input         bin;
        begin
            sub_w = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, ~bin};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Condition evaluation
    reg cond_v;
    always @* begin
        case (cc_i)
            `SSX_CC_CARRY: cond_v = status_o[`SSX_ST_CF];
            `SSX_CC_ZERO:  cond_v = status_o[`SSX_ST_ZF];
            `SSX_CC_TAG:   cond_v = status_o[`SSX_ST_TAG];
            `SSX_CC_RZ:    cond_v = (index_reg_i == {W{1'b0}});
            `SSX_CC_RNZ:   cond_v = (index_reg_i != {W{1'b0}});
            `SSX_CC_RNEG:  cond_v = index_reg_i[W-1];
            `SSX_CC_RNNEG: cond_v = ~index_reg_i[W-1];
            default:       cond_v = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Per-word datapath of the string engine
    wire [AW-1:0] da     = dst_q + idx_q;
    wire [AW-1:0] sa     = src_q + idx_q;
    wire [W-1:0]  opb    = mem_q ? mem_data_i : acc_q[sa];
    wire [W:0]    diff   = sub_w(acc_q[da], opb, borrow_q);
    wire          ovf    = (acc_q[da][W-1] ^ opb[W-1]) & (acc_q[da][W-1] ^ diff[W-1]);
    wire          last   = (idx_q == cnt_q);
    wire          zchain = zacc_q & (diff[W-1:0] == {W{1'b0}});

    // Immediate ops at issue
    wire [AW-1:0] ptr_n  = ptr_mod(acc_pointer_o, mod_i);
    wire [AW-1:0] xd     = dst_i + ptr_n;
    wire [AW-1:0] xs     = src_i + ptr_n;
    wire [W-1:0]  xop    = use_mem_i ? mem_data_i : acc_q[xs];
    wire [W-1:0]  xres   = acc_q[xd] ^ xop;
    wire [W-1:0]  shsrc  = acc_q[xs];
    wire [W-1:0]  shres  = {status_o[`SSX_ST_XM] & shsrc[W-1], shsrc[W-1:1]};
    // product high subtracted from the second word
    wire [AW-1:0] phd    = dst_i + {{(AW-1){1'b0}}, 1'b1};
    wire [W:0]    phdiff = sub_w(acc_q[phd], product_high_reg_i, ~status_o[`SSX_ST_CF]);
    wire          phovf  = (acc_q[phd][W-1] ^ product_high_reg_i[W-1]) & (acc_q[phd][W-1] ^ phdiff[W-1]);
    wire          tf_cur = tf_sel_i ? status_o[`SSX_ST_TF2] : status_o[`SSX_ST_TF1];

    ////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < NACC; i = i + 1) begin
                acc_q[i] <= {W{1'b0}};
            end
            state_q       <= ST_IDLE;
            op_q          <= `SSX_OP_NONE;
            dst_q         <= {AW{1'b0}};
            src_q         <= {AW{1'b0}};
            cnt_q         <= {AW{1'b0}};
            idx_q         <= {AW{1'b0}};
            mem_q         <= 1'b0;
            borrow_q      <= 1'b0;
            zacc_q        <= 1'b1;
            pc_q          <= 16'h0000;
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            pc_o          <= 16'h0000;
            push_o        <= 1'b0;
            push_data_o   <= 16'h0000;
            vec_addr_o    <= 16'h0000;
            status_o      <= `SSX_STAT_RST;
            acc_pointer_o <= {AW{1'b0}};
            acc_rd_o      <= {W{1'b0}};
        end else begin
            done_o   <= 1'b0;
            push_o   <= 1'b0;
            acc_rd_o <= acc_q[acc_addr_i];
            if (acc_we_i && state_q == ST_IDLE) begin
                acc_q[acc_addr_i] <= acc_data_i;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start_i) begin
                        case (op_i)
                            `SSX_OP_STRING_SUBTRACT: begin
                                dst_q    <= dst_i;
                                src_q    <= src_i;
                                cnt_q    <= count_i;
                                mem_q    <= use_mem_i;
                                idx_q    <= {AW{1'b0}};
                                borrow_q <= 1'b0;
                                zacc_q   <= 1'b1;
                                busy_o   <= 1'b1;
                                state_q  <= ST_RUN;
                            end
                            `SSX_OP_STRING_SUBTRACT_PH: begin
                                acc_q[phd]            <= phdiff[W-1:0];
                                status_o[`SSX_ST_CF]  <= phdiff[W];
                                status_o[`SSX_ST_ZF]  <= status_o[`SSX_ST_ZF] & (phdiff[W-1:0] == {W{1'b0}});
                                status_o[`SSX_ST_SF]  <= phdiff[W-1];
                                status_o[`SSX_ST_OF]  <= phovf;
                                pc_o                  <= pc_i + 16'h0001;
                                done_o                <= 1'b1;
                            end
                            `SSX_OP_SXM: begin
                                status_o[`SSX_ST_XM] <= 1'b1;
                                pc_o                 <= pc_i + 16'h0001;
                                done_o               <= 1'b1;
                            end
                            `SSX_OP_VECTORED_CALL: begin
                                push_o      <= 1'b1;
                                push_data_o <= pc_i + 16'h0001;
                                vec_addr_o  <= `SSX_VEC_BASE + {8'h00, vector_i};
                                busy_o      <= 1'b1;
                                state_q     <= ST_VEC;
                            end
                            `SSX_OP_XOR: begin
                                acc_pointer_o        <= ptr_n;
                                acc_q[xd]            <= xres;
                                status_o[`SSX_ST_ZF] <= (xres == {W{1'b0}});
                                status_o[`SSX_ST_SF] <= xres[W-1];
                                status_o[`SSX_ST_OF] <= 1'b0;
                                status_o[`SSX_ST_CF] <= 1'b0;
                                if (use_mem_i) begin
                                    status_o[`SSX_ST_TAG] <= mem_tag_i;
                                end
                                pc_o   <= pc_i + 16'h0001;
                                done_o <= 1'b1;
                            end
                            `SSX_OP_XOR_TFM: begin
                                status_o[`SSX_ST_TAG] <= mem_tag_i;
                                if (tf_sel_i) begin
                                    status_o[`SSX_ST_TF2] <= tf_cur ^ (mem_tag_i ^ flag_not_i);
                                end else begin
                                    status_o[`SSX_ST_TF1] <= tf_cur ^ (mem_tag_i ^ flag_not_i);
                                end
                                pc_o   <= pc_i + 16'h0001;
                                done_o <= 1'b1;
                            end
                            `SSX_OP_XOR_TFC: begin
                                if (tf_sel_i) begin
                                    status_o[`SSX_ST_TF2] <= tf_cur ^ (cond_v ^ flag_not_i);
                                end else begin
                                    status_o[`SSX_ST_TF1] <= tf_cur ^ (cond_v ^ flag_not_i);
                                end
                                pc_o   <= pc_i + 16'h0001;
                                done_o <= 1'b1;
                            end
                            `SSX_OP_SHR: begin
                                acc_pointer_o        <= ptr_n;
                                acc_q[xd]            <= shres;
                                status_o[`SSX_ST_ZF] <= (shres == {W{1'b0}});
                                status_o[`SSX_ST_SF] <= shres[W-1];
                                status_o[`SSX_ST_CF] <= shsrc[0];
                                status_o[`SSX_ST_OF] <= 1'b0;
                                pc_o   <= pc_i + 16'h0001;
                                done_o <= 1'b1;
                            end
                            default: begin
                                done_o <= 1'b0;
                            end
                        endcase
                        pc_q <= pc_i;
                    end
                end
                ST_RUN: begin
                    acc_q[da] <= diff[W-1:0];
                    borrow_q <= ~diff[W];
                    zacc_q   <= zchain;
                    idx_q    <= idx_q + {{(AW-1){1'b0}}, 1'b1};
                    if (last) begin
                        status_o[`SSX_ST_CF]  <= diff[W];
                        status_o[`SSX_ST_ZF]  <= zchain;
                        status_o[`SSX_ST_SF]  <= diff[W-1];
                        status_o[`SSX_ST_OF]  <= ovf;
                        if (mem_q) begin
                            status_o[`SSX_ST_TAG] <= mem_tag_i;
                        end
                        pc_o    <= pc_q + 16'h0001;
                        done_o  <= 1'b1;
                        busy_o  <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_VEC: begin
                    pc_o    <= mem_data_i;
                    done_o  <= 1'b1;
                    busy_o  <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // ssx_exec

// *** sim/ssx_prog_model.sv ***
// Program memory model: vector table word and operand word
`timescale 1ns/1ns
module ssx_prog_model #(
    parameter [15:0] TBL_KEY = 16'h5a5a
) (
    // Design side
    input  wire        push_i,
    input  wire [15:0] vec_addr_i,
    // Bench side
    input  wire [15:0] word_i,
    output wire [15:0] mem_data_o
);
    // table routines never open with a plain return
    assign mem_data_o = push_i ? (vec_addr_i ^ TBL_KEY) : word_i;
endmodule // ssx_prog_model

// *** sim/ssx_exec_props.sv ***
// Port checker for the execution unit
`timescale 1ns/1ns
`include "ssx_defines.vh"
module ssx_exec_props #(
    parameter W  = 16,
    parameter AW = 3
) (
    input wire          sys_clk_i,
    input wire          rstn_i,
    input wire          start_i,
    input wire [3:0]    op_i,
    input wire [15:0]   pc_i,
    input wire [7:0]    vector_i,
    input wire          tf_sel_i,
    input wire          flag_not_i,
    input wire          use_mem_i,
    input wire [1:0]    mod_i,
    input wire [AW-1:0] count_i,
    input wire [W-1:0]  mem_data_i,
    input wire          mem_tag_i,
    input wire          busy_o,
    input wire          done_o,
    input wire [15:0]   pc_o,
    input wire          push_o,
    input wire [15:0]   push_data_o,
    input wire [15:0]   vec_addr_o,
    input wire [7:0]    status_o,
    input wire [AW-1:0] acc_pointer_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire iss = start_i && !busy_o;
    property p_sxm;
        iss && op_i == `SSX_OP_SXM |=> done_o && status_o[0] && pc_o == $past(pc_i) + 16'h1;
    endproperty
    a_sxm: assert property (p_sxm) else $error("sign mode set wrong");
    property p_keep;
        iss && op_i == `SSX_OP_SXM |=> status_o[7:1] == $past(status_o[7:1]);
    endproperty
    a_keep: assert property (p_keep) else $error("sign mode touched flags");
    property p_push;
        iss && op_i == `SSX_OP_VECTORED_CALL |=> push_o && push_data_o == $past(pc_i) + 16'h1
            && vec_addr_o == `SSX_VEC_BASE + {8'h00, $past(vector_i)};
    endproperty
    a_push: assert property (p_push) else $error("vector push wrong");
    property p_vpc;
        iss && op_i == `SSX_OP_VECTORED_CALL |=> !done_o ##1 done_o && pc_o == $past(mem_data_i);
    endproperty
    a_vpc: assert property (p_vpc) else $error("vector target wrong");
    property p_ph;
        iss && op_i == `SSX_OP_STRING_SUBTRACT_PH |=> done_o && !busy_o;
    endproperty
    a_ph: assert property (p_ph) else $error("product high not single");
    property p_string_subtract;
        iss && op_i == `SSX_OP_STRING_SUBTRACT && count_i == 1 |=> !done_o ##[1:2] done_o;
    endproperty
    a_string_subtract: assert property (p_string_subtract) else $error("string length wrong");
    property p_xmem;
        iss && op_i == `SSX_OP_XOR && use_mem_i |=> status_o[7] == $past(mem_tag_i) && !status_o[3] && !status_o[6];
    endproperty
    a_xmem: assert property (p_xmem) else $error("xor flags wrong");
    property p_tfm;
        iss && op_i == `SSX_OP_XOR_TFM && !tf_sel_i |=>
            status_o[1] == ($past(status_o[1]) ^ $past(mem_tag_i) ^ $past(flag_not_i));
    endproperty
    a_tfm: assert property (p_tfm) else $error("test flag wrong");
    property p_inc;
        iss && op_i == `SSX_OP_XOR && mod_i == `SSX_MOD_INC |=> acc_pointer_o == $past(acc_pointer_o) + 1'b1;
    endproperty
    a_inc: assert property (p_inc) else $error("pointer step wrong");
    c_vc: cover property (push_o);
    c_ph: cover property (iss && op_i == `SSX_OP_STRING_SUBTRACT_PH);
    c_tf: cover property (iss && op_i == `SSX_OP_XOR_TFC);
endmodule // ssx_exec_props
bind ssx_exec ssx_exec_props #(.W(W), .AW(AW)) ssx_exec_props_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .start_i(start_i), .op_i(op_i), .pc_i(pc_i), .vector_i(vector_i), .tf_sel_i(tf_sel_i),
    .flag_not_i(flag_not_i), .use_mem_i(use_mem_i), .mod_i(mod_i), .count_i(count_i),
    .mem_data_i(mem_data_i), .mem_tag_i(mem_tag_i), .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o),
    .push_o(push_o), .push_data_o(push_data_o), .vec_addr_o(vec_addr_o), .status_o(status_o),
    .acc_pointer_o(acc_pointer_o));

// *** sim/ssx_exec_tb.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/1ns
`include "ssx_defines.vh"
module ssx_exec_tb;
    reg         sys_clk_i, rstn_i, start_i, use_mem_i, tf_sel_i, flag_not_i, mem_tag_i, acc_we_i;
    reg  [3:0]  op_i;
    reg  [2:0]  dst_i, src_i, count_i, acc_addr_i, cc_i;
    reg  [1:0]  mod_i;
    reg  [15:0] pc_i, word_i, index_reg_i, product_high_reg_i, acc_data_i, pd, va;
    reg  [7:0]  vector_i;
    wire [15:0] mem_data_i, pc_o, push_data_o, vec_addr_o, acc_rd_o;
    wire        busy_o, done_o, push_o;
    wire [7:0]  status_o;
    wire [2:0]  acc_pointer_o;
    integer     mismatches, total_checks, cycles, lat;
    ssx_exec ssx_exec_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .start_i(start_i), .op_i(op_i),
        .dst_i(dst_i), .src_i(src_i), .use_mem_i(use_mem_i), .mod_i(mod_i), .count_i(count_i), .pc_i(pc_i),
        .vector_i(vector_i), .tf_sel_i(tf_sel_i), .flag_not_i(flag_not_i), .cc_i(cc_i),
        .index_reg_i(index_reg_i), .mem_data_i(mem_data_i), .mem_tag_i(mem_tag_i),
        .product_high_reg_i(product_high_reg_i), .acc_we_i(acc_we_i), .acc_addr_i(acc_addr_i),
        .acc_data_i(acc_data_i), .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o), .push_o(push_o),
        .push_data_o(push_data_o), .vec_addr_o(vec_addr_o), .status_o(status_o),
        .acc_pointer_o(acc_pointer_o), .acc_rd_o(acc_rd_o));
    ssx_prog_model ssx_prog_model_i (.push_i(push_o), .vec_addr_i(vec_addr_o), .word_i(word_i),
        .mem_data_o(mem_data_i));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (push_o === 1'b1) begin
            pd <= push_data_o;
            va <= vec_addr_o;
        end
        cycles = cycles + 1;
        if (cycles == 2000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    task chk(input [15:0] seen, input [15:0] exp, input [63:0] what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("Error %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task go(input [3:0] op);
        begin
            op_i <= op;
            start_i <= 1'b1;
            @(posedge sys_clk_i);
            start_i <= 1'b0;
            #1 lat = 0;
            while (done_o !== 1'b1 && lat < 9) begin
                @(posedge sys_clk_i);
                #1 lat = lat + 1;
            end
        end
    endtask
    task ld(input [2:0] a, input [15:0] d);
        begin
            acc_we_i <= 1'b1;
            acc_addr_i <= a;
            acc_data_i <= d;
            @(posedge sys_clk_i);
            #1;
        end
    endtask
    task rd(input [2:0] a, input [15:0] exp);
        begin
            acc_addr_i <= a;
            @(posedge sys_clk_i);
            #1 chk(acc_rd_o, exp, "acc");
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_sxm;
        begin
            pc_i <= 16'h00ff;
            go(`SSX_OP_SXM);
            chk(lat[15:0], 16'h0, "lat");
            chk(pc_o, 16'h0100, "pc");
            chk({8'h00, status_o}, 16'h0001, "stat");
        end
    endtask
    task t_vectored_call;
        begin
            pc_i <= 16'h0123;
            vector_i <= 8'hff;
            go(`SSX_OP_VECTORED_CALL);
            chk(pd, 16'h0124, "push");
            chk(va, 16'h7fff, "vaddr");
            chk(pc_o, 16'h7fff ^ 16'h5a5a, "pc");
        end
    endtask
    task t_string_subtract;
        begin
            ld(3'h0, 16'h0000);
            ld(3'h1, 16'h0001);
            ld(3'h2, 16'h0001);
            ld(3'h3, 16'h0000);
            acc_we_i <= 1'b0;
            dst_i <= 3'h0;
            src_i <= 3'h2;
            count_i <= 3'h1;
            go(`SSX_OP_STRING_SUBTRACT);
            chk(lat[15:0], 16'h2, "lat");
            chk({8'h00, status_o}, 16'h0041, "stat");
            rd(3'h0, 16'hffff);
            rd(3'h1, 16'h0000);
            // product-high form directly after a carry-setting op
            // issued back to back, no step or interrupt between
            product_high_reg_i <= 16'h0001;
            count_i <= 3'h3;
            go(`SSX_OP_STRING_SUBTRACT_PH);
            chk(lat[15:0], 16'h0, "lat");
            chk({8'h00, status_o}, 16'h0011, "stat");
            rd(3'h0, 16'hffff);
            rd(3'h1, 16'hffff);
        end
    endtask
    task t_xor;
        begin
            mod_i <= `SSX_MOD_INC;
            use_mem_i <= 1'b1;
            word_i <= 16'h0f0f;
            mem_tag_i <= 1'b1;
            go(`SSX_OP_XOR);
            chk({13'h0, acc_pointer_o}, 16'h1, "ptr");
            chk({8'h00, status_o}, 16'h0091, "stat");
            rd(3'h1, 16'hf0f0);
            mod_i <= `SSX_MOD_DEC;
            use_mem_i <= 1'b0;
            src_i <= 3'h1;
            word_i <= 16'hf0f0;
            go(`SSX_OP_XOR);
            chk({13'h0, acc_pointer_o}, 16'h0, "ptr");
            chk({8'h00, status_o}, 16'h0081, "stat");
            rd(3'h0, 16'h0f0f);
        end
    endtask
    task t_flags;
        begin
            mod_i <= `SSX_MOD_NONE;
            go(`SSX_OP_XOR_TFM);
            chk({8'h00, status_o}, 16'h0083, "stat");
            tf_sel_i <= 1'b1;
            go(`SSX_OP_XOR_TFM);
            chk({8'h00, status_o}, 16'h0087, "stat");
            // index value only beside register conditions
            tf_sel_i <= 1'b0;
            cc_i <= `SSX_CC_RZ;
            index_reg_i <= 16'h0000;
            go(`SSX_OP_XOR_TFC);
            chk({8'h00, status_o}, 16'h0085, "stat");
            index_reg_i <= 16'h0005;
            go(`SSX_OP_XOR_TFC);
            chk({8'h00, status_o}, 16'h0085, "stat");
            cc_i <= `SSX_CC_RNEG;
            index_reg_i <= 16'h8000;
            go(`SSX_OP_XOR_TFC);
            chk({8'h00, status_o}, 16'h0087, "stat");
        end
    endtask
    task t_shr;
        begin
            ld(3'h2, 16'h8000);
            acc_we_i <= 1'b0;
            dst_i <= 3'h2;
            src_i <= 3'h2;
            go(`SSX_OP_SHR);
            rd(3'h2, 16'hc000);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {start_i, use_mem_i, tf_sel_i, flag_not_i, mem_tag_i, acc_we_i, rstn_i} = 7'h00;
        {op_i, dst_i, src_i, count_i, acc_addr_i, cc_i, mod_i} = 21'h0;
        {pc_i, word_i, index_reg_i, product_high_reg_i, acc_data_i} = 80'h0;
        vector_i = 8'h00;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        repeat (2) @(posedge sys_clk_i);
        #1 rstn_i <= 1'b1;
        chk({busy_o, status_o}, 16'h0, "reset");
        chk(pc_o, 16'h0, "reset");
        t_sxm;
        t_vectored_call;
        t_string_subtract;
        t_xor;
        t_flags;
        t_shr;
        close_out;
    end
endmodule // ssx_exec_tb
